// ### hw/tpwm_top.sv
/*
  four pwm channels and two own timers behind a classic wishbone slave.
  channels two and three take their frame from an external shared timer
  given as count and overflow pulse; tick inputs are one-cycle enables.
*/
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module tpwm_top
  import tpwm_pkg::*;
(
  input wire logic clk_i, // 100 mhz system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic cyc_i, // wishbone cycle
  input wire logic stb_i, // wishbone strobe
  input wire logic we_i, // wishbone write
  input wire logic [7:0] adr_i, // wishbone byte address
  input wire logic [3:0] sel_i, // wishbone byte selects
  input wire logic [31:0] dat_i, // wishbone write data
  output logic ack_o, // wishbone acknowledge
  output logic [31:0] dat_o, // wishbone read data
  input wire logic instr_tick_i, // instruction clock enable
  input wire logic fast_rc_tick_i, // fast rc enable
  input wire logic ext_count_pin_i, // external count pin
  input wire logic [TPWM_DW-1:0] shared_count_i, // shared timer count
  input wire logic shared_overflow_i, // shared timer underflow pulse
  output logic [1:0] ch2_pin_o, // ch2 candidate pin levels
  output logic [1:0] ch2_pin_oe_o, // ch2 candidate pin enables
  output logic [1:0] ch3_pin_o, // ch3 candidate pin levels
  output logic [1:0] ch3_pin_oe_o, // ch3 candidate pin enables
  output logic ch4_pin_o, // ch4 pin level
  output logic ch4_pin_oe_o, // ch4 pin enable
  output logic ch5_pin_o, // ch5 pin level
  output logic ch5_pin_oe_o, // ch5 pin enable
  output logic irq_o // interrupt request
);
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [31:0] rd_data;
  tpwm_chan_cfg_t chan_cfg_reg [4];
  logic [TPWM_DW-1:0] duty_buf_reg [4];
  logic [1:0] duty_hi_reg [4];
  logic [1:0] pin_sel_reg;
  tpwm_tmr_cfg_t tmr_cfg_reg [2];
  logic [TPWM_DW-1:0] reload_buf_reg [2];
  logic [1:0] reload_hi_reg [2];
  logic [1:0] flag_reg;
  logic [1:0] flag_next;
  logic [1:0] ie_reg;
  logic gie_reg;
  logic irq_reg;
  logic irq_next;
  logic [TPWM_DW-1:0] tmr_count [2];
  logic [TPWM_PSW-1:0] tmr_ps [2];
  logic [1:0] tmr_uf;
  logic [TPWM_DW-1:0] ch_count [4];
  logic [3:0] ch_update;
  logic [3:0] ch_sel;
  logic [1:0] ch_pin [4];
  logic [1:0] ch_oe [4];

  wire req = cyc_i && stb_i && !ack_reg;
  wire wr_stb = req && we_i;
  wire rd_stb = req && !we_i;
  wire [7:0] ofs = {adr_i[7:2], 2'b00};
  wire irq_wr = wr_stb && sel_i[0] && (ofs == TPWM_IRQ_OFS);
  wire pin_wr = wr_stb && sel_i[0] && (ofs == TPWM_PIN_OFS);

  genvar i;
  genvar k;
  for (i = 0; i < 4; i++) begin : g_ch
    wire ctrl_wr = wr_stb && sel_i[0] && (ofs == TPWM_CTRL_OFS[i]);
    wire duty_hit = wr_stb && (ofs == TPWM_DUTY_OFS[i]);
    wire duty_wr_hi = duty_hit && sel_i[1];
    wire duty_wr_lo = duty_hit && sel_i[0];
    // upper bits wait until the low byte completes the value
    wire [1:0] duty_hi_val = duty_wr_hi ? dat_i[9:8] : duty_hi_reg[i];

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        chan_cfg_reg[i] <= TPWM_CHAN_CFG_RST;
        duty_buf_reg[i] <= '0;
        duty_hi_reg[i] <= '0;
      end else begin
        if (ctrl_wr) begin
          chan_cfg_reg[i] <= '{oen: dat_i[TPWM_OEN_BIT],
                               active_low: dat_i[TPWM_AL_BIT]};
        end
        duty_hi_reg[i] <= duty_hi_val;
        if (duty_wr_lo) begin
          duty_buf_reg[i] <= {duty_hi_val, dat_i[7:0]};
        end
      end
    end

    if (i < 2) begin : g_shared
      assign ch_count[i] = shared_count_i;
      assign ch_update[i] = shared_overflow_i;
      assign ch_sel[i] = pin_sel_reg[i];
    end else begin : g_own
      assign ch_count[i] = tmr_count[i-2];
      assign ch_update[i] = tmr_uf[i-2];
      assign ch_sel[i] = 1'b0;
    end

    tpwm_chan u_chan (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cfg_i(chan_cfg_reg[i]),
      .pin_sel_i(ch_sel[i]),
      .duty_i(duty_buf_reg[i]),
      .count_i(ch_count[i]),
      .update_i(ch_update[i]),
      .pin_o(ch_pin[i]),
      .pin_oe_o(ch_oe[i])
    );
  end

  for (k = 0; k < 2; k++) begin : g_tmr
    wire cta_wr = wr_stb && sel_i[0] && (ofs == TPWM_CTRL_OFS[k+2]);
    wire ctb_wr = wr_stb && sel_i[0] && (ofs == TPWM_CTB_OFS[k]);
    wire rld_hit = wr_stb && (ofs == TPWM_RLD_OFS[k]);
    wire rld_wr_hi = rld_hit && sel_i[1];
    wire rld_wr_lo = rld_hit && sel_i[0];
    wire [1:0] rld_hi_val = rld_wr_hi ? dat_i[9:8] : reload_hi_reg[k];
    wire [TPWM_DW-1:0] rld_val = {rld_hi_val, dat_i[7:0]};
    wire load_now = rld_wr_lo && !tmr_cfg_reg[k].enable;

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        tmr_cfg_reg[k] <= TPWM_TMR_CFG_RST;
        reload_buf_reg[k] <= '0;
        reload_hi_reg[k] <= '0;
      end else begin
        if (cta_wr) begin
          tmr_cfg_reg[k].enable <= dat_i[TPWM_EN_BIT];
          tmr_cfg_reg[k].fast_rc <= dat_i[TPWM_HRC_BIT];
          tmr_cfg_reg[k].one_shot <= dat_i[TPWM_OS_BIT];
          tmr_cfg_reg[k].reload_sel <= dat_i[TPWM_RLS_BIT];
        end
        if (ctb_wr) begin
          tmr_cfg_reg[k].clock_sel <= dat_i[TPWM_CS_BIT];
          tmr_cfg_reg[k].edge_sel <= dat_i[TPWM_CE_BIT];
          tmr_cfg_reg[k].ps_en_n <= dat_i[TPWM_PSN_BIT];
          tmr_cfg_reg[k].ps_ratio <= dat_i[TPWM_PSR_LSB +: 3];
        end
        reload_hi_reg[k] <= rld_hi_val;
        if (rld_wr_lo) begin
          reload_buf_reg[k] <= rld_val;
        end
      end
    end

    tpwm_timer u_tmr (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cfg_i(tmr_cfg_reg[k]),
      .instr_tick_i(instr_tick_i),
      .fast_rc_tick_i(fast_rc_tick_i),
      .ext_pin_i(ext_count_pin_i),
      .reload_i(reload_buf_reg[k]),
      .load_now_i(load_now),
      .load_val_i(rld_val),
      .count_o(tmr_count[k]),
      .ps_count_o(tmr_ps[k]),
      .underflow_o(tmr_uf[k])
    );

    // a new underflow beats a clear that lands in the same cycle
    assign flag_next[k] = tmr_uf[k] || (flag_reg[k] &&
                          !(irq_wr && !dat_i[TPWM_FLAG_LSB+k]));
  end

  assign irq_next = gie_reg && |(flag_reg & ie_reg);

  always_comb begin
    rd_data = '0;
    for (int c = 0; c < 4; c++) begin
      if (ofs == TPWM_DUTY_OFS[c]) begin
        rd_data[TPWM_DW-1:0] = duty_buf_reg[c];
      end
      if (ofs == TPWM_CTRL_OFS[c]) begin
        rd_data[TPWM_OEN_BIT] = chan_cfg_reg[c].oen;
        rd_data[TPWM_AL_BIT] = chan_cfg_reg[c].active_low;
      end
    end
    for (int t = 0; t < 2; t++) begin
      if (ofs == TPWM_CTRL_OFS[t+2]) begin
        rd_data[TPWM_EN_BIT] = tmr_cfg_reg[t].enable;
        rd_data[TPWM_HRC_BIT] = tmr_cfg_reg[t].fast_rc;
        rd_data[TPWM_OS_BIT] = tmr_cfg_reg[t].one_shot;
        rd_data[TPWM_RLS_BIT] = tmr_cfg_reg[t].reload_sel;
      end
      if (ofs == TPWM_CTB_OFS[t]) begin
        rd_data[TPWM_CS_BIT] = tmr_cfg_reg[t].clock_sel;
        rd_data[TPWM_CE_BIT] = tmr_cfg_reg[t].edge_sel;
        rd_data[TPWM_PSN_BIT] = tmr_cfg_reg[t].ps_en_n;
        rd_data[TPWM_PSR_LSB +: 3] = tmr_cfg_reg[t].ps_ratio;
      end
      if (ofs == TPWM_RLD_OFS[t]) begin
        rd_data[TPWM_DW-1:0] = tmr_count[t];
      end
      if (ofs == TPWM_PSC_OFS[t]) begin
        rd_data[TPWM_PSW-1:0] = tmr_ps[t];
      end
    end
    if (ofs == TPWM_IRQ_OFS) begin
      rd_data[TPWM_FLAG_LSB +: 2] = flag_reg;
      rd_data[TPWM_IE_LSB +: 2] = ie_reg;
      rd_data[TPWM_GIE_BIT] = gie_reg;
    end
    if (ofs == TPWM_PIN_OFS) begin
      rd_data[1:0] = pin_sel_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
      flag_reg <= '0;
      ie_reg <= '0;
      gie_reg <= 1'b0;
      irq_reg <= 1'b0;
      pin_sel_reg <= '0;
    end else begin
      ack_reg <= req;
      dat_reg <= rd_stb ? rd_data : '0;
      flag_reg <= flag_next;
      irq_reg <= irq_next;
      if (irq_wr) begin
        ie_reg <= dat_i[TPWM_IE_LSB +: 2];
        gie_reg <= dat_i[TPWM_GIE_BIT];
      end
      if (pin_wr) begin
        pin_sel_reg <= dat_i[1:0];
      end
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;
  assign irq_o = irq_reg;
  assign ch2_pin_o = ch_pin[0];
  assign ch2_pin_oe_o = ch_oe[0];
  assign ch3_pin_o = ch_pin[1];
  assign ch3_pin_oe_o = ch_oe[1];
  assign ch4_pin_o = ch_pin[2][0];
  assign ch4_pin_oe_o = ch_oe[2][0];
  assign ch5_pin_o = ch_pin[3][0];
  assign ch5_pin_oe_o = ch_oe[3][0];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_single_a: assert property (
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  flag_set_a: assert property (
    tmr_uf[0] |=> flag_reg[0] [*2])
    else $error("underflow flag not set or not sticky");
  irq_gate_a: assert property (
    (gie_reg && flag_reg[1] && ie_reg[1]) |=> irq_o)
    else $error("enabled flag did not raise irq");
  count_read_a: assert property (
    (rd_stb && ofs == TPWM_RLD_OFS[0]) |=>
      (ack_o && dat_o[TPWM_DW-1:0] == $past(tmr_count[0])))
    else $error("reload read did not return the count");

  uf_seen_c: cover property (tmr_uf[0] ##1 flag_reg[0]);
  irq_seen_c: cover property (irq_o);
  pwm_active_c: cover property (ch4_pin_oe_o && ch4_pin_o);
  clear_race_c: cover property (irq_wr && tmr_uf[1]);
endmodule : tpwm_top

// ### hw/tpwm_pkg.sv
/*
  shared constants, register map and carrier types for the pwm/timer block.
  assumes a 32-bit classic wishbone slave and a single 100 mhz clock.
*/
package tpwm_pkg;
  localparam int TPWM_DW = 10;
  localparam int TPWM_PSW = 8;
  localparam logic [9:0] TPWM_CNT_MAX = 10'h3ff;
  localparam logic [9:0] TPWM_CNT_RST = 10'h000;
  localparam logic [7:0] TPWM_PS_ONES = 8'hff;
  localparam logic [2:0] TPWM_PS_TOP = 3'h7;
  // byte offsets, one aligned word each
  localparam logic [7:0] TPWM_CTRL_OFS [4] = '{8'h00, 8'h04, 8'h10, 8'h24};
  localparam logic [7:0] TPWM_DUTY_OFS [4] = '{8'h08, 8'h0c, 8'h1c, 8'h30};
  localparam logic [7:0] TPWM_CTB_OFS [2] = '{8'h14, 8'h28};
  localparam logic [7:0] TPWM_RLD_OFS [2] = '{8'h18, 8'h2c};
  localparam logic [7:0] TPWM_PSC_OFS [2] = '{8'h20, 8'h34};
  localparam logic [7:0] TPWM_IRQ_OFS = 8'h38;
  localparam logic [7:0] TPWM_PIN_OFS = 8'h3c;
  // control word a (and channel control) fields
  localparam int TPWM_OEN_BIT = 7;
  localparam int TPWM_AL_BIT = 6;
  localparam int TPWM_HRC_BIT = 3;
  localparam int TPWM_OS_BIT = 2;
  localparam int TPWM_RLS_BIT = 1;
  localparam int TPWM_EN_BIT = 0;
  // control word b fields
  localparam int TPWM_CS_BIT = 5;
  localparam int TPWM_CE_BIT = 4;
  localparam int TPWM_PSN_BIT = 3;
  localparam int TPWM_PSR_LSB = 0;
  // interrupt word fields
  localparam int TPWM_FLAG_LSB = 0;
  localparam int TPWM_IE_LSB = 2;
  localparam int TPWM_GIE_BIT = 4;

  typedef struct packed {
    logic oen;
    logic active_low;
  } tpwm_chan_cfg_t;

  typedef struct packed {
    logic enable;
    logic fast_rc;
    logic one_shot;
    logic reload_sel;
    logic clock_sel;
    logic edge_sel;
    logic ps_en_n;
    logic [2:0] ps_ratio;
  } tpwm_tmr_cfg_t;

  localparam tpwm_chan_cfg_t TPWM_CHAN_CFG_RST = '{oen: 1'b0,
                                                  active_low: 1'b0};
  localparam tpwm_tmr_cfg_t TPWM_TMR_CFG_RST = '{enable: 1'b0,
    fast_rc: 1'b0, one_shot: 1'b0, reload_sel: 1'b0, clock_sel: 1'b0,
    edge_sel: 1'b0, ps_en_n: 1'b1, ps_ratio: 3'h0};
endpackage : tpwm_pkg

// ### hw/tpwm_chan.sv
/*
  one pwm output channel: active duty register, comparator, polarity and
  two candidate pins. assumes a down-counting period count and an
  underflow pulse from the timer that owns the frame.
*/
`timescale 1ns/1ps
module tpwm_chan
  import tpwm_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset
  input wire tpwm_chan_cfg_t cfg_i, // enable and polarity
  input wire logic pin_sel_i, // 0 first pin, 1 second pin
  input wire logic [TPWM_DW-1:0] duty_i, // buffered duty
  input wire logic [TPWM_DW-1:0] count_i, // frame count
  input wire logic update_i, // frame timer underflow
  output logic [1:0] pin_o, // pin levels
  output logic [1:0] pin_oe_o // pin drive enables
);
  logic [TPWM_DW-1:0] duty_act_reg;
  logic [TPWM_DW-1:0] duty_act_next;
  logic [1:0] pin_reg;
  logic [1:0] oe_reg;
  logic [1:0] pin_next;
  logic [1:0] oe_next;
  wire active = count_i < duty_act_reg;
  wire level = active ^ cfg_i.active_low;

  // duty changes only at frame end so no frame is ever cut short
  assign duty_act_next = update_i ? duty_i : duty_act_reg;

  genvar j;
  for (j = 0; j < 2; j++) begin : g_pin
    assign pin_next[j] = level;
    assign oe_next[j] = cfg_i.oen && (pin_sel_i == 1'(j));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      duty_act_reg <= '0;
      pin_reg <= '0;
      oe_reg <= '0;
    end else begin
      duty_act_reg <= duty_act_next;
      pin_reg <= pin_next;
      oe_reg <= oe_next;
    end
  end

  assign pin_o = pin_reg;
  assign pin_oe_o = oe_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  zero_duty_idle_a: assert property (
    (duty_act_reg == '0) |=> (pin_o[0] == $past(cfg_i.active_low)))
    else $error("zero duty drove the output active");
  duty_hold_a: assert property (
    !update_i |=> $stable(duty_act_reg))
    else $error("active duty changed outside frame end");
  oe_follow_a: assert property (
    (cfg_i.oen && !pin_sel_i) |=> (pin_oe_o == 2'b01))
    else $error("enabled channel did not drive its first pin");
endmodule : tpwm_chan

// ### hw/tpwm_timer.sv
/*
  10-bit down-counting timer with clock select, edge select, power of two
  prescaler, one shot and auto reload. assumes one-cycle tick pulses for
  the instruction clock and fast rc, and a pin level synchronous to clk_i.
*/
`timescale 1ns/1ps
module tpwm_timer
  import tpwm_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset
  input wire tpwm_tmr_cfg_t cfg_i, // timer configuration
  input wire logic instr_tick_i, // instruction clock tick
  input wire logic fast_rc_tick_i, // fast rc tick
  input wire logic ext_pin_i, // external count pin level
  input wire logic [TPWM_DW-1:0] reload_i, // buffered reload
  input wire logic load_now_i, // immediate load strobe
  input wire logic [TPWM_DW-1:0] load_val_i, // value for immediate load
  output logic [TPWM_DW-1:0] count_o, // present count
  output logic [TPWM_PSW-1:0] ps_count_o, // present prescaler count
  output logic underflow_o // one-cycle underflow pulse
);
  logic [TPWM_DW-1:0] count_reg;
  logic [TPWM_DW-1:0] count_next;
  logic [TPWM_PSW-1:0] ps_reg;
  logic ext_prev_reg;
  logic done_reg;
  logic done_next;
  logic uf_reg;
  logic uf_next;

  wire ext_rise = ext_pin_i && !ext_prev_reg;
  wire ext_fall = !ext_pin_i && ext_prev_reg;
  wire ext_tick = cfg_i.edge_sel ? ext_fall : ext_rise;
  wire src_tick = cfg_i.fast_rc ? fast_rc_tick_i :
                  (cfg_i.clock_sel ? ext_tick : instr_tick_i);
  wire [TPWM_PSW-1:0] ps_mask = TPWM_PS_ONES >>
                                (TPWM_PS_TOP - cfg_i.ps_ratio);
  wire ps_full = (ps_reg & ps_mask) == ps_mask;
  wire cnt_tick = cfg_i.ps_en_n ? src_tick : (src_tick && ps_full);
  wire run = cfg_i.enable && !done_reg && cnt_tick;

  always_comb begin
    count_next = count_reg;
    done_next = done_reg;
    uf_next = 1'b0;
    if (load_now_i) begin
      count_next = load_val_i;
      done_next = 1'b0;
    end else if (!cfg_i.enable) begin
      done_next = 1'b0;
    end else if (run) begin
      if (count_reg == '0) begin
        uf_next = 1'b1;
        if (cfg_i.one_shot) begin
          done_next = 1'b1;
        end else begin
          count_next = cfg_i.reload_sel ? reload_i : TPWM_CNT_MAX;
        end
      end else begin
        count_next = count_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= TPWM_CNT_RST;
      ps_reg <= '0;
      ext_prev_reg <= 1'b0;
      done_reg <= 1'b0;
      uf_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      // prescaler is held clear while bypassed
      ps_reg <= cfg_i.ps_en_n ? '0 : (src_tick ? ps_reg + 1'b1 : ps_reg);
      ext_prev_reg <= ext_pin_i;
      done_reg <= done_next;
      uf_reg <= uf_next;
    end
  end

  assign count_o = count_reg;
  assign ps_count_o = ps_reg;
  assign underflow_o = uf_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  load_now_a: assert property (
    load_now_i |=> (count_o == $past(load_val_i)))
    else $error("immediate load did not reach the counter");
  one_shot_stop_a: assert property (
    (done_reg && cfg_i.enable && !load_now_i) |=> $stable(count_o))
    else $error("one shot timer kept counting");
  restart_val_a: assert property (
    (run && !load_now_i && count_reg == '0 && !cfg_i.one_shot) |=>
      (underflow_o && count_o == ($past(cfg_i.reload_sel) ?
        $past(reload_i) : TPWM_CNT_MAX)))
    else $error("wrong restart value after underflow");
endmodule : tpwm_timer

// ### bench/tpwm_load.sv
/*
  load model on one pwm pin: resolves the pin level and tallies high cycles.
  assumes a pull-down on the pin while the block leaves it undriven.
*/
`timescale 1ns/1ps
module tpwm_load (
  input wire logic clk_i, // system clock
  input wire logic clr_i, // clear the tally
  input wire logic en_i, // tally window
  input wire logic pin_i, // level offered by the block
  input wire logic oe_i, // block drives the pin
  output logic [15:0] high_cnt_o // cycles seen high
);
  logic level;
  // undriven pin falls to the pull-down, so a lost enable reads as low
  assign level = oe_i ? pin_i : 1'b0;
  always_ff @(posedge clk_i) begin
    if (clr_i) begin
      high_cnt_o <= 16'h0;
    end else if (en_i && level) begin
      high_cnt_o <= high_cnt_o + 16'h1;
    end
  end
endmodule : tpwm_load

// ### bench/tpwm_top_test.sv
/*
  self-checking bench for tpwm_top: wishbone tasks, shared timer model,
  pin loads. assumes instruction ticks every cycle; fast rc ticks come
  only where a scenario pulses them.
*/
`timescale 1ns/1ps
module tpwm_top_test;
  import tpwm_pkg::*;
  localparam logic [31:0] M_OEN = 32'h1 << TPWM_OEN_BIT;
  localparam logic [31:0] M_AL = 32'h1 << TPWM_AL_BIT;
  localparam logic [31:0] M_OS = 32'h1 << TPWM_OS_BIT;
  localparam logic [31:0] M_RLS = 32'h1 << TPWM_RLS_BIT;
  localparam logic [31:0] M_EN = 32'h1 << TPWM_EN_BIT;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, irq, p4, oe4, p5, oe5, clr = 1'b0, en = 1'b0;
  logic itick = 1'b1, xpin = 1'b0, sh_run = 1'b0, sh_ovf = 1'b0;
  logic frc = 1'b0;
  logic [9:0] sh_cnt = 10'h0;
  logic [1:0] p2, oe2, p3, oe3;
  logic [15:0] h2, h3, h4, h5;
  int miscompares = 0;
  int comparisons = 0;

  always #5 clk = ~clk;
  // shared frame timer: eight counts, one-cycle pulse at underflow
  always @(posedge clk) begin
    if (sh_run) begin
      sh_ovf <= (sh_cnt == 10'h0);
      sh_cnt <= (sh_cnt == 10'h0) ? 10'h7 : sh_cnt - 10'h1;
    end
  end

  tpwm_top i_tpwm_top (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'h3), .dat_i(wdat), .ack_o(ack),
    .dat_o(rdat), .instr_tick_i(itick), .fast_rc_tick_i(frc),
    .ext_count_pin_i(xpin), .shared_count_i(sh_cnt),
    .shared_overflow_i(sh_ovf), .ch2_pin_o(p2), .ch2_pin_oe_o(oe2),
    .ch3_pin_o(p3), .ch3_pin_oe_o(oe3), .ch4_pin_o(p4), .ch4_pin_oe_o(oe4),
    .ch5_pin_o(p5), .ch5_pin_oe_o(oe5), .irq_o(irq));
  tpwm_load i_tpwm_load_2 (.clk_i(clk), .clr_i(clr), .en_i(en),
    .pin_i(p2[1]), .oe_i(oe2[1]), .high_cnt_o(h2));
  tpwm_load i_tpwm_load_3 (.clk_i(clk), .clr_i(clr), .en_i(en),
    .pin_i(p3[0]), .oe_i(oe3[0]), .high_cnt_o(h3));
  tpwm_load i_tpwm_load_4 (.clk_i(clk), .clr_i(clr), .en_i(en),
    .pin_i(p4), .oe_i(oe4), .high_cnt_o(h4));
  tpwm_load i_tpwm_load_5 (.clk_i(clk), .clr_i(clr), .en_i(en),
    .pin_i(p5), .oe_i(oe5), .high_cnt_o(h5));

  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    if (n >= 20) begin
      miscompares++;
      tally_and_finish();
    end
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd

  // window of n samples on every load
  task automatic measure(input int n);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    en <= 1'b1;
    repeat (n) @(posedge clk);
    en <= 1'b0;
    @(posedge clk);
  endtask : measure

  task automatic t_reset();
    chk(32'({p2, oe2, p4, oe4, p5, oe5, irq}), 32'h0);
    rd(TPWM_CTB_OFS[0], 32'h8);
    rd(TPWM_CTRL_OFS[2], 32'h0);
    rd(8'h40, 32'h0);
  endtask : t_reset

  task automatic t_ch4();
    wb(1'b1, TPWM_RLD_OFS[0], 32'h3);
    rd(TPWM_RLD_OFS[0], 32'h3);
    wb(1'b1, TPWM_DUTY_OFS[2], 32'h1);
    wb(1'b1, TPWM_IRQ_OFS, 32'h14);
    wb(1'b1, TPWM_CTRL_OFS[2], M_OEN | M_RLS | M_EN);
    repeat (12) @(posedge clk);
    measure(40);
    chk(32'(h4), 32'd10);
    chk(32'(irq), 32'h1);
    wb(1'b1, TPWM_CTRL_OFS[2], M_OEN | M_AL | M_RLS | M_EN);
    measure(40);
    chk(32'(h4), 32'd30);
    wb(1'b1, TPWM_CTRL_OFS[2], M_EN);
    repeat (8) @(posedge clk);
    wb(1'b0, TPWM_RLD_OFS[0], 32'h0);
    chk(32'(q[9:4]), 32'h3f);
    wb(1'b1, TPWM_CTRL_OFS[2], 32'h0);
    wb(1'b1, TPWM_IRQ_OFS, 32'h14);
    rd(TPWM_IRQ_OFS, 32'h14);
    chk(32'(irq), 32'h0);
  endtask : t_ch4

  // instruction ticks keep running and must be ignored here
  task automatic t_ext();
    xpin <= 1'b1;
    wb(1'b1, TPWM_RLD_OFS[0], 32'ha);
    wb(1'b1, TPWM_CTB_OFS[0], 32'h38);
    wb(1'b1, TPWM_CTRL_OFS[2], M_EN);
    for (int i = 0; i < 3; i++) begin
      xpin <= ~xpin;
      repeat (8) @(posedge clk);
    end
    rd(TPWM_RLD_OFS[0], 32'h8);
    wb(1'b1, TPWM_CTB_OFS[0], 32'h30);
    for (int i = 0; i < 8; i++) begin
      xpin <= ~xpin;
      repeat (8) @(posedge clk);
    end
    rd(TPWM_RLD_OFS[0], 32'h6);
    wb(1'b1, TPWM_CTRL_OFS[2], 32'h0);
    // fast rc must win over the running instruction ticks
    wb(1'b1, TPWM_RLD_OFS[0], 32'ha);
    wb(1'b1, TPWM_CTB_OFS[0], 32'h8);
    wb(1'b1, TPWM_CTRL_OFS[2], M_EN | (32'h1 << TPWM_HRC_BIT));
    for (int i = 0; i < 3; i++) begin
      frc <= 1'b1;
      @(posedge clk);
      frc <= 1'b0;
      @(posedge clk);
    end
    rd(TPWM_RLD_OFS[0], 32'h7);
    wb(1'b1, TPWM_CTRL_OFS[2], 32'h0);
  endtask : t_ext

  task automatic t_ch5();
    wb(1'b1, TPWM_RLD_OFS[1], 32'h3ff);
    wb(1'b1, TPWM_DUTY_OFS[3], 32'h3ff);
    wb(1'b1, TPWM_CTRL_OFS[3], M_OEN | M_RLS | M_EN);
    repeat (1100) @(posedge clk);
    measure(2048);
    chk(32'(h5), 32'd2046);
    wb(1'b1, TPWM_DUTY_OFS[3], 32'h0);
    repeat (1100) @(posedge clk);
    measure(1024);
    chk(32'(h5), 32'd0);
    chk(32'(oe5), 32'h1);
    wb(1'b1, TPWM_CTRL_OFS[3], 32'h0);
    wb(1'b1, TPWM_IRQ_OFS, 32'h14);
    wb(1'b1, TPWM_RLD_OFS[1], 32'h5);
    wb(1'b1, TPWM_CTRL_OFS[3], M_OS | M_EN);
    repeat (30) @(posedge clk);
    rd(TPWM_RLD_OFS[1], 32'h0);
    rd(TPWM_IRQ_OFS, 32'h16);
  endtask : t_ch5

  // duty 3 against an eight-count shared frame
  task automatic t_ch2();
    wb(1'b1, TPWM_PIN_OFS, 32'h1);
    wb(1'b1, TPWM_CTRL_OFS[0], M_OEN);
    wb(1'b1, TPWM_CTRL_OFS[1], M_OEN | M_AL);
    wb(1'b1, TPWM_DUTY_OFS[0], 32'h3);
    wb(1'b1, TPWM_DUTY_OFS[1], 32'h5);
    measure(16);
    chk(32'(h2), 32'h0);
    chk(32'(h3), 32'd16);
    chk(32'(oe2), 32'h2);
    chk(32'(oe3), 32'h1);
    sh_run <= 1'b1;
    repeat (20) @(posedge clk);
    measure(64);
    chk(32'(h2), 32'd24);
    chk(32'(h3), 32'd24);
  endtask : t_ch2

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_ch4();
    t_ext();
    t_ch5();
    t_ch2();
    tally_and_finish();
  end
endmodule : tpwm_top_test
